// ==== logic/psd_pkg.sv ====
// shared constants, field layouts and carriers of the synthesizer core
package psd_pkg;

  // serial word and routing field
  localparam int WORD_W          = 24;
  localparam int ROUTE_HI        = 1;
  localparam int ROUTE_LO        = 0;
  localparam logic [1:0] ROUTE_REF  = 2'h0;
  localparam logic [1:0] ROUTE_FB   = 2'h1;
  localparam logic [1:0] ROUTE_FUNC = 2'h2;

  // reference divider word layout
  localparam int REF_RATIO_W     = 14;
  localparam int REF_RATIO_TOP   = 15;
  localparam int REF_RATIO_LSB   = 2;
  localparam int BACKLASH_TOP    = 17;
  localparam int BACKLASH_LSB    = 16;

  // feedback divider word layout
  localparam int MAIN_W          = 13;
  localparam int MAIN_TOP        = 20;
  localparam int MAIN_LSB        = 8;
  localparam int SWALLOW_W       = 6;
  localparam int SWALLOW_TOP     = 7;
  localparam int SWALLOW_LSB     = 2;
  localparam int LOCK_PREC_POS   = 22;

  // control setup word layout
  localparam int PRESC_TOP       = 23;
  localparam int PRESC_LSB       = 22;
  localparam int PUMP_CUR_TOP    = 17;
  localparam int PUMP_CUR_LSB    = 15;
  localparam int PUMP_TRI_POS    = 8;
  localparam int POLARITY_POS    = 7;
  localparam int MUX_TOP         = 6;
  localparam int MUX_LSB         = 4;
  localparam int SOFT_PD_POS     = 3;
  localparam int CNT_RESET_POS   = 2;

  // prescaler modulus: base shifted left by the two select bits
  localparam int PRESC_W              = 7;
  localparam logic [PRESC_W-1:0] PRESC_BASE = 7'h08;

  // output multiplexer codes
  localparam logic [2:0] MUX_LOW  = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_FB   = 3'h2;
  localparam logic [2:0] MUX_HIGH = 3'h3;
  localparam logic [2:0] MUX_REF  = 3'h4;

  // lock detect timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int LD_COARSE_NS    = 10;
  localparam int LD_FINE_NS      = 3;
  localparam int LD_UNLOCK_NS    = 25;
  localparam int LD_GOOD_CYCLES  = 5;
  localparam int ERR_W           = 4;
  localparam int ERR_NS_W        = 10;

  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;

  typedef struct packed {
    logic [1:0]             backlash;
    logic [REF_RATIO_W-1:0] ratio;
  } psd_ref_cfg_t;

  typedef struct packed {
    logic                 lock_precision;
    logic [MAIN_W-1:0]    main_count;
    logic [SWALLOW_W-1:0] swallow_count;
  } psd_fb_cfg_t;

  typedef struct packed {
    logic [1:0] presc_sel;
    logic [2:0] pump_current;
    logic       pump_tristate;
    logic       polarity;
    logic [2:0] mux_sel;
    logic       soft_pd;
    logic       counter_reset;
  } psd_func_cfg_t;

endpackage : psd_pkg

// ==== logic/psd_fb_div.sv ====
// pulse-swallow feedback divider behind the dual-modulus prescaler
`timescale 1ns/1ps
module psd_fb_div
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   hold_in,
  input  wire logic                   rf_tick_in,
  input  wire logic [psd_pkg::PRESC_W-1:0] presc_p_in,
  input  wire psd_pkg::psd_fb_cfg_t   cfg_in,
  output logic                        fb_pulse_out
);
  import psd_pkg::*;

  logic [PRESC_W-1:0]   presc_cnt_q;
  logic [MAIN_W-1:0]    main_left_q;
  logic [SWALLOW_W-1:0] swal_left_q;
  logic [PRESC_W-1:0]   modulus;
  logic                 presc_wrap;
  logic                 main_end;

  // modulus p+1 while swallow count remains, then p
  assign modulus    = (swal_left_q != '0) ? presc_p_in + 7'h01
                                          : presc_p_in;
  assign presc_wrap = rf_tick_in && (presc_cnt_q + 7'h01 >= modulus);
  assign main_end   = (main_left_q <= 13'h0001);

  // hold keeps every counter at its load point so release is aligned
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      presc_cnt_q  <= '0;
      main_left_q  <= '0;
      swal_left_q  <= '0;
      fb_pulse_out <= 1'b0;
    end
    else if (hold_in)
    begin
      presc_cnt_q  <= '0;
      main_left_q  <= cfg_in.main_count;
      swal_left_q  <= cfg_in.swallow_count;
      fb_pulse_out <= 1'b0;
    end
    else
    begin
      fb_pulse_out <= presc_wrap && main_end;
      if (presc_wrap)
      begin
        presc_cnt_q <= '0;
        if (main_end)
        begin
          main_left_q <= cfg_in.main_count;
          swal_left_q <= cfg_in.swallow_count;
        end
        else
        begin
          main_left_q <= main_left_q - 13'h0001;
          if (swal_left_q != '0)
            swal_left_q <= swal_left_q - 6'h01;
        end
      end
      else if (rf_tick_in)
        presc_cnt_q <= presc_cnt_q + 7'h01;
    end
  end

endmodule : psd_fb_div

// ==== logic/psd_core.sv ====
// digital core: serial port, latches, dividers, lock detect, muxout
// How it works
// - host sends msb first; one bit shifts in per serial clock rise.
// - load strobe rise copies the word into the latch its low bits pick.
// - reference divided by 14-bit ratio in bits 15..2, range 1..16383.
// - main feedback count is bits 20..8, valid 3..8191.
// - swallow count is bits 7..2, valid 0..63.
// - feedback divides by main times modulus plus swallow count, for swallow not above main.
// - bits 23..22 of control word pick the dual prescaler modulus.
// - lock sets after five cycles under 10 ns, or 3 ns if precise.
// - lock stays until a later cycle shows error above 25 ns.
// - counter reset bit 2 holds reference and feedback counters.
// - on release feedback restarts aligned with the reference counter.
// - latched soft power-down bit 3 powers down at once.
// - chip enable low powers down regardless of soft bit.
// - power-down loads counters, tri-states pump, resets lock detect.
// - serial port keeps loading latches during power-down.
// - mux select bits 6..4 choose the muxout source.
// - pump current code in bits 17..15.
// - pump tri-state bit 8: one high impedance, zero enabled unless counters are held.
// - bit 7 sets phase detector polarity.
// - muxout can show lock detect, divided rf or divided reference.
`timescale 1ns/1ps
module psd_core
(
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       SER_CLK_IN,
  input  wire logic       SER_DATA_IN,
  input  wire logic       LOAD_STROBE_IN,
  input  wire logic       CHIP_ENABLE_IN,
  input  wire logic       REF_CLK_IN,
  input  wire logic       RF_CLK_IN,
  output logic            MUX_OUT,
  output logic            LOCK_DETECT_OUT,
  output logic            REF_DIV_OUT,
  output logic            FB_DIV_OUT,
  output logic            POWERED_DOWN_OUT,
  output logic            PUMP_TRISTATE_OUT,
  output logic [2:0]      PUMP_CURRENT_OUT,
  output logic            DETECTOR_POLARITY_OUT,
  output logic [1:0]      BACKLASH_WIDTH_OUT,
  output logic [psd_pkg::PRESC_W-1:0] PRESC_MODULUS_OUT
);
  import psd_pkg::*;

  // serial port state
  logic [WORD_W-1:0]      shift_q;
  logic                   ser_clk_prev_q;
  logic                   load_prev_q;
  logic [WORD_W-1:0]      ref_word_q;
  logic [WORD_W-1:0]      fb_word_q;
  logic [WORD_W-1:0]      func_word_q;

  // edge detection on sampled pins
  logic                   ser_rise;
  logic                   load_rise;
  logic                   ref_prev_q;
  logic                   rf_prev_q;
  logic                   ref_tick;
  logic                   rf_tick;

  // decoded latch fields
  psd_ref_cfg_t           ref_cfg;
  psd_fb_cfg_t            fb_cfg;
  psd_func_cfg_t          func_cfg;
  logic [1:0]             route;
  logic                   pick_ref;
  logic                   pick_fb;
  logic                   pick_func;

  // divider and lock state
  logic                   power_down;
  logic                   counters_hold;
  logic [REF_RATIO_W-1:0] ref_cnt_q;
  logic                   ref_wrap;
  logic                   ref_pulse_q;
  logic                   fb_pulse;
  logic [PRESC_W-1:0]     presc_p;
  logic                   ref_seen_q;
  logic                   fb_seen_q;
  logic [ERR_W-1:0]       err_cnt_q;
  logic                   ref_hit;
  logic                   fb_hit;
  logic                   pd_done;
  logic                   waiting;
  logic [ERR_NS_W-1:0]    err_ns;
  logic [ERR_NS_W-1:0]    good_limit_ns;
  logic                   err_good;
  logic                   err_bad;
  logic [2:0]             good_cnt_q;
  logic                   lock_q;
  logic                   mux_d;

  // serial clock, strobe, reference and rf edges; pins are synchronous to the clock
  assign ser_rise  = SER_CLK_IN && !ser_clk_prev_q;
  assign load_rise = LOAD_STROBE_IN && !load_prev_q;
  assign ref_tick  = REF_CLK_IN && !ref_prev_q;
  assign rf_tick   = RF_CLK_IN && !rf_prev_q;

  // routing decode from the two lowest word bits
  assign route     = shift_q[ROUTE_HI:ROUTE_LO];
  assign pick_ref  = load_rise && (route == ROUTE_REF);
  assign pick_fb   = load_rise && (route == ROUTE_FB);
  assign pick_func = load_rise && (route == ROUTE_FUNC);

  // shift register and edge history; never gated by power-down
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      shift_q        <= WORD_RESET;
      ser_clk_prev_q <= 1'b0;
      load_prev_q    <= 1'b0;
      ref_prev_q     <= 1'b0;
      rf_prev_q      <= 1'b0;
    end
    else
    begin
      ser_clk_prev_q <= SER_CLK_IN;
      load_prev_q    <= LOAD_STROBE_IN;
      ref_prev_q     <= REF_CLK_IN;
      rf_prev_q      <= RF_CLK_IN;
      if (ser_rise)
        shift_q <= {shift_q[WORD_W-2:0], SER_DATA_IN};
    end
  end

  // destination latches; a route of 11 is simply dropped
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ref_word_q  <= WORD_RESET;
      fb_word_q   <= WORD_RESET;
      func_word_q <= WORD_RESET;
    end
    else
    begin
      if (pick_ref)
        ref_word_q <= shift_q;
      if (pick_fb)
        fb_word_q <= shift_q;
      if (pick_func)
        func_word_q <= shift_q;
    end
  end

  // field extraction; reserved bits are not looked at
  assign ref_cfg.backlash  = ref_word_q[BACKLASH_TOP:BACKLASH_LSB];
  assign ref_cfg.ratio     = ref_word_q[REF_RATIO_TOP:REF_RATIO_LSB];
  assign fb_cfg.lock_precision = fb_word_q[LOCK_PREC_POS];
  assign fb_cfg.main_count     = fb_word_q[MAIN_TOP:MAIN_LSB];
  assign fb_cfg.swallow_count  = fb_word_q[SWALLOW_TOP:SWALLOW_LSB];
  assign func_cfg.presc_sel     = func_word_q[PRESC_TOP:PRESC_LSB];
  assign func_cfg.pump_current  = func_word_q[PUMP_CUR_TOP:PUMP_CUR_LSB];
  assign func_cfg.pump_tristate = func_word_q[PUMP_TRI_POS];
  assign func_cfg.polarity      = func_word_q[POLARITY_POS];
  assign func_cfg.mux_sel       = func_word_q[MUX_TOP:MUX_LSB];
  assign func_cfg.soft_pd       = func_word_q[SOFT_PD_POS];
  assign func_cfg.counter_reset = func_word_q[CNT_RESET_POS];

  // modulus p = 8 << select, so 8, 16, 32, 64; p+1 comes from swallowing
  assign presc_p = PRESC_BASE << func_cfg.presc_sel;

  // power-down from either source, and the shared counter hold
  assign power_down    = !CHIP_ENABLE_IN || func_cfg.soft_pd;
  assign counters_hold = power_down || func_cfg.counter_reset;

  // reference divider; a ratio of zero behaves as one
  assign ref_wrap = ref_tick &&
                    ({1'b0, ref_cnt_q} + 15'h0001 >= {1'b0, ref_cfg.ratio});

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ref_cnt_q   <= '0;
      ref_pulse_q <= 1'b0;
    end
    else if (counters_hold)
    begin
      ref_cnt_q   <= '0;
      ref_pulse_q <= 1'b0;
    end
    else
    begin
      ref_pulse_q <= ref_wrap;
      if (ref_wrap)
        ref_cnt_q <= '0;
      else if (ref_tick)
        ref_cnt_q <= ref_cnt_q + 14'h0001;
    end
  end

  // feedback divider shares the same hold so both restart together
  psd_fb_div u_fb_div
  (
    .clk_in       (SYS_CLK_IN),
    .rst_n_in     (RST_N_IN),
    .hold_in      (counters_hold),
    .rf_tick_in   (rf_tick),
    .presc_p_in   (presc_p),
    .cfg_in       (fb_cfg),
    .fb_pulse_out (fb_pulse)
  );

  // phase error: cycles between the two divider edges of one pd cycle;
  // resolution is one clock period, so sub-period errors read as zero
  assign ref_hit = ref_seen_q || ref_pulse_q;
  assign fb_hit  = fb_seen_q || fb_pulse;
  assign pd_done = ref_hit && fb_hit;
  assign waiting = (ref_seen_q || fb_seen_q) && !pd_done;
  assign err_ns  = ERR_NS_W'(err_cnt_q * CLK_PERIOD_NS);
  assign good_limit_ns = fb_cfg.lock_precision ?
                         ERR_NS_W'(LD_FINE_NS) : ERR_NS_W'(LD_COARSE_NS);
  assign err_good = err_ns < good_limit_ns;
  assign err_bad  = err_ns > ERR_NS_W'(LD_UNLOCK_NS);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ref_seen_q <= 1'b0;
      fb_seen_q  <= 1'b0;
      err_cnt_q  <= '0;
    end
    else if (power_down)
    begin
      ref_seen_q <= 1'b0;
      fb_seen_q  <= 1'b0;
      err_cnt_q  <= '0;
    end
    else if (pd_done)
    begin
      ref_seen_q <= 1'b0;
      fb_seen_q  <= 1'b0;
      err_cnt_q  <= '0;
    end
    else
    begin
      ref_seen_q <= ref_hit;
      fb_seen_q  <= fb_hit;
      if (waiting || ref_pulse_q || fb_pulse)
      begin
        if (err_cnt_q != '1)     // saturate on a stalled divider
          err_cnt_q <= err_cnt_q + 4'h1;
      end
    end
  end

  // lock detect: five good cycles in a row to set, one bad to clear
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      good_cnt_q <= '0;
      lock_q     <= 1'b0;
    end
    else if (power_down)
    begin
      good_cnt_q <= '0;
      lock_q     <= 1'b0;
    end
    else if (pd_done)
    begin
      if (lock_q)
      begin
        if (err_bad)
        begin
          lock_q     <= 1'b0;
          good_cnt_q <= '0;
        end
      end
      else if (!err_good)
        good_cnt_q <= '0;
      else if (good_cnt_q == 3'(LD_GOOD_CYCLES - 1))
      begin
        lock_q     <= 1'b1;
        good_cnt_q <= '0;
      end
      else
        good_cnt_q <= good_cnt_q + 3'h1;
    end
  end

  // muxout source select; unlisted codes drive low
  always_comb
  begin
    unique case (func_cfg.mux_sel)
      MUX_LOCK: mux_d = lock_q;
      MUX_FB:   mux_d = fb_pulse;
      MUX_REF:  mux_d = ref_pulse_q;
      MUX_HIGH: mux_d = 1'b1;
      default:  mux_d = 1'b0;
    endcase
  end

  // every output is a flop; costs one cycle of latency on each
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      MUX_OUT               <= 1'b0;
      LOCK_DETECT_OUT       <= 1'b0;
      REF_DIV_OUT           <= 1'b0;
      FB_DIV_OUT            <= 1'b0;
      POWERED_DOWN_OUT      <= 1'b1;
      PUMP_TRISTATE_OUT     <= 1'b1;
      PUMP_CURRENT_OUT      <= '0;
      DETECTOR_POLARITY_OUT <= 1'b0;
      BACKLASH_WIDTH_OUT    <= '0;
      PRESC_MODULUS_OUT     <= PRESC_BASE;
    end
    else
    begin
      MUX_OUT               <= mux_d;
      LOCK_DETECT_OUT       <= lock_q;
      REF_DIV_OUT           <= ref_pulse_q;
      FB_DIV_OUT            <= fb_pulse;
      POWERED_DOWN_OUT      <= power_down;
      PUMP_TRISTATE_OUT     <= counters_hold ||
                               func_cfg.pump_tristate;
      PUMP_CURRENT_OUT      <= func_cfg.pump_current;
      DETECTOR_POLARITY_OUT <= func_cfg.polarity;
      BACKLASH_WIDTH_OUT    <= ref_cfg.backlash;
      PRESC_MODULUS_OUT     <= presc_p;
    end
  end

endmodule : psd_core

// ==== verification/psd_host_model.sv ====
// behavioural host that shifts words into the core over the serial port
`timescale 1ns/1ps
module psd_host_model
(
  input  wire logic clk_in,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      load_out
);
  // idle levels before the first frame; the serial clock stands low
  initial
  begin
    ser_clk_out  = 1'b0;
    ser_data_out = 1'b0;
    load_out     = 1'b0;
  end

  // one word msb first; hold gives cycles per clock phase, so the host
  // runs at full rate or slowly; data is valid only while clock is high
  task automatic send(input logic [23:0] word, input int hold);
    for (int i = 23; i >= 0; i--)
    begin
      @(negedge clk_in);
      ser_data_out = word[i];
      ser_clk_out  = 1'b1;
      repeat (hold) @(negedge clk_in);
      ser_clk_out  = 1'b0;
      ser_data_out = ~word[i]; // no hold time: line shows the inverse
      repeat (hold - 1) @(negedge clk_in);
    end
    @(negedge clk_in);
    load_out = 1'b1;
    repeat (hold) @(negedge clk_in);
    load_out = 1'b0;
  endtask : send
endmodule : psd_host_model

// ==== verification/psd_core_properties.sv ====
// concurrent checks on the ports of the synthesizer core
`timescale 1ns/1ps
module psd_core_properties
(
  input wire logic                   SYS_CLK_IN,
  input wire logic                   RST_N_IN,
  input wire logic                   SER_CLK_IN,
  input wire logic                   SER_DATA_IN,
  input wire logic                   LOAD_STROBE_IN,
  input wire logic                   CHIP_ENABLE_IN,
  input wire logic                   REF_CLK_IN,
  input wire logic                   RF_CLK_IN,
  input wire logic                   MUX_OUT,
  input wire logic                   LOCK_DETECT_OUT,
  input wire logic                   REF_DIV_OUT,
  input wire logic                   FB_DIV_OUT,
  input wire logic                   POWERED_DOWN_OUT,
  input wire logic                   PUMP_TRISTATE_OUT,
  input wire logic [2:0]             PUMP_CURRENT_OUT,
  input wire logic                   DETECTOR_POLARITY_OUT,
  input wire logic [1:0]             BACKLASH_WIDTH_OUT,
  input wire logic [psd_pkg::PRESC_W-1:0] PRESC_MODULUS_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // chip enable low powers the core down on the next clock
  property p_ce_pd;
    !CHIP_ENABLE_IN |=> POWERED_DOWN_OUT;
  endproperty
  a_ce_pd: assert property (p_ce_pd)
    else $error("chip enable low without power-down");

  property p_pd_pump;
    POWERED_DOWN_OUT |-> PUMP_TRISTATE_OUT;
  endproperty
  a_pd_pump: assert property (p_pd_pump)
    else $error("pump driven during power-down");

  property p_pd_lock;
    POWERED_DOWN_OUT |=> !LOCK_DETECT_OUT;
  endproperty
  a_pd_lock: assert property (p_pd_lock)
    else $error("lock detect held during power-down");

  // pipeline drains in two clocks, so three are allowed
  property p_pd_quiet;
    POWERED_DOWN_OUT [*3] |-> !REF_DIV_OUT && !FB_DIV_OUT;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("divider pulse during power-down");

  property p_ref_single;
    REF_DIV_OUT |=> !REF_DIV_OUT;
  endproperty
  a_ref_single: assert property (p_ref_single)
    else $error("reference pulse longer than one clock");

  property p_fb_single;
    FB_DIV_OUT |=> !FB_DIV_OUT;
  endproperty
  a_fb_single: assert property (p_fb_single)
    else $error("feedback pulse longer than one clock");

  property p_modulus;
    PRESC_MODULUS_OUT inside {7'h08, 7'h10, 7'h20, 7'h40};
  endproperty
  a_modulus: assert property (p_modulus)
    else $error("prescaler modulus not a legal value");

  // settings move only after a strobe rise
  property p_cfg_hold;
    !LOAD_STROBE_IN [*3] |-> $stable({PUMP_CURRENT_OUT,
      DETECTOR_POLARITY_OUT, BACKLASH_WIDTH_OUT, PRESC_MODULUS_OUT});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("setting changed without a load");

  property p_lock_up;
    $rose(LOCK_DETECT_OUT) |-> !$past(POWERED_DOWN_OUT);
  endproperty
  a_lock_up: assert property (p_lock_up)
    else $error("lock rose straight out of power-down");
endmodule : psd_core_properties

bind psd_core psd_core_properties u_psd_core_properties
(
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .SER_CLK_IN(SER_CLK_IN),
  .SER_DATA_IN(SER_DATA_IN), .LOAD_STROBE_IN(LOAD_STROBE_IN),
  .CHIP_ENABLE_IN(CHIP_ENABLE_IN), .REF_CLK_IN(REF_CLK_IN),
  .RF_CLK_IN(RF_CLK_IN), .MUX_OUT(MUX_OUT),
  .LOCK_DETECT_OUT(LOCK_DETECT_OUT), .REF_DIV_OUT(REF_DIV_OUT),
  .FB_DIV_OUT(FB_DIV_OUT), .POWERED_DOWN_OUT(POWERED_DOWN_OUT),
  .PUMP_TRISTATE_OUT(PUMP_TRISTATE_OUT),
  .PUMP_CURRENT_OUT(PUMP_CURRENT_OUT),
  .DETECTOR_POLARITY_OUT(DETECTOR_POLARITY_OUT),
  .BACKLASH_WIDTH_OUT(BACKLASH_WIDTH_OUT),
  .PRESC_MODULUS_OUT(PRESC_MODULUS_OUT)
);

// ==== verification/psd_core_tb.sv ====
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
module psd_core_tb;
  import psd_pkg::*;
  localparam logic [1:0] BL_SETTING = 2'h2; // arbitrary nonzero code
  logic               sys_clk, rst_n, ce, ref_clk, rf_clk;
  wire logic          ser_clk, ser_data, load;
  logic               mux_o, lock_o, ref_o, fb_o, pd_o, tri_o, pol_o;
  logic [2:0]         cur_o, cur;
  logic [1:0]         bl_o, sel;
  logic [PRESC_W-1:0] mod_o;
  logic               pol;
  int                 n_mismatch, n_compared, n_ref, n_fb, n_mux, cyc;
  int                 seed = 32'h27fc0078;
  int                 r, b, a, n;

  psd_core u_psd_core (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n),
    .SER_CLK_IN(ser_clk), .SER_DATA_IN(ser_data), .LOAD_STROBE_IN(load),
    .CHIP_ENABLE_IN(ce), .REF_CLK_IN(ref_clk), .RF_CLK_IN(rf_clk),
    .MUX_OUT(mux_o), .LOCK_DETECT_OUT(lock_o), .REF_DIV_OUT(ref_o),
    .FB_DIV_OUT(fb_o), .POWERED_DOWN_OUT(pd_o), .PUMP_TRISTATE_OUT(tri_o),
    .PUMP_CURRENT_OUT(cur_o), .DETECTOR_POLARITY_OUT(pol_o),
    .BACKLASH_WIDTH_OUT(bl_o), .PRESC_MODULUS_OUT(mod_o));
  psd_host_model u_psd_host_model (.clk_in(sys_clk), .ser_clk_out(ser_clk),
    .ser_data_out(ser_data), .load_out(load));

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // pulse counters and the hang limit
  always @(posedge sys_clk)
  begin
    cyc++;
    if (ref_o === 1'b1) n_ref++;
    if (fb_o === 1'b1) n_fb++;
    if (mux_o === 1'b1) n_mux++;
    if (cyc >= 50000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // word builders keep every reserved position at zero
  function automatic logic [23:0] ref_word(input int rr);
    return {6'h00, BL_SETTING, 14'(rr), 2'h0};
  endfunction : ref_word
  function automatic logic [23:0] fb_word(input logic p, input int bb,
                                          input int aa);
    return {1'b0, p, 1'b0, 13'(bb), 6'(aa), 2'h1};
  endfunction : fb_word
  function automatic logic [23:0] fn_word(input logic [1:0] s,
    input logic [2:0] c, input logic t, input logic p, input logic [2:0] m,
    input logic spd, input logic crst);
    return {s, 4'h0, c, 6'h00, t, p, m, spd, crst, 2'h2};
  endfunction : fn_word
  function automatic logic [6:0] modulus(input logic [1:0] s);
    case (s)
      2'h0: return 7'h08;
      2'h1: return 7'h10;
      2'h2: return 7'h20;
      default: return 7'h40;
    endcase
  endfunction : modulus

  // random pace exercises both the fast and the slow host
  task automatic load_word(input logic [23:0] w);
    u_psd_host_model.send(w, 1 + ($random(seed) & 1) * 2);
    repeat (2) @(negedge sys_clk);
  endtask : load_word

  // k rises on the chosen inputs, then a short drain
  task automatic run(input int k, input logic dr, input logic df);
    n_ref = 0;
    n_fb = 0;
    n_mux = 0;
    for (int i = 0; i < k; i++)
    begin
      @(negedge sys_clk);
      ref_clk = dr;
      rf_clk = df;
      @(negedge sys_clk);
      ref_clk = 1'b0;
      rf_clk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask : run

  // counter reset pulse aligns both dividers, then seven aligned cycles
  task automatic lock_up;
    load_word(fn_word(2'h0, 3'h0, 1'b0, 1'b0, MUX_LOCK, 1'b0, 1'b1));
    load_word(fn_word(2'h0, 3'h0, 1'b0, 1'b0, MUX_LOCK, 1'b0, 1'b0));
    run(24 * 7, 1'b1, 1'b1);
  endtask : lock_up

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b0;
    ref_clk = 1'b0;
    rf_clk = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("pd_reset", pd_o, 32'h1);
    check("tri_reset", tri_o, 32'h1);
    check("mod_reset", mod_o, 32'h8);
    rst_n = 1'b1;
    ce = 1'b1;
    // every prescaler code, with a dropped route-11 word after each
    for (int i = 0; i < 4; i++)
    begin
      sel = 2'(i);
      cur = 3'($random(seed));
      pol = 1'($random(seed));
      load_word(fn_word(sel, cur, sel[0], pol, MUX_HIGH, 1'b0, 1'b0));
      check("modulus", mod_o, modulus(sel));
      check("pump_cur", cur_o, cur);
      check("polarity", pol_o, pol);
      check("tristate", tri_o, sel[0]);
      check("mux_high", mux_o, 32'h1);
      load_word(fn_word(~sel, ~cur, 1'b1, ~pol, 3'h0, 1'b1, 1'b1) | 24'h1);
      check("route3", {cur_o, mod_o}, {cur, modulus(sel)});
    end
    // all mux codes with the dividers idle
    for (int c = 0; c < 8; c++)
    begin
      load_word(fn_word(2'h0, 3'h0, 1'b0, 1'b0, 3'(c), 1'b0, 1'b0));
      check("mux_idle", mux_o, c == 3);
    end
    // reference ratio 1 and a random one; counter reset stops counting
    for (int j = 0; j < 2; j++)
    begin
      r = j ? 2 + ($unsigned($random(seed)) % 8) : 1;
      load_word(fn_word(2'h0, 3'h0, 1'b0, 1'b0, MUX_REF, 1'b0, 1'b1));
      load_word(ref_word(r));
      check("backlash", bl_o, BL_SETTING);
      run(r * 3, 1'b1, 1'b0);
      check("ref_held", n_ref, 32'h0);
      check("tri_held", tri_o, 32'h1);
      load_word(fn_word(2'h0, 3'h0, 1'b0, 1'b0, MUX_REF, 1'b0, 1'b0));
      run(r * 6, 1'b1, 1'b0);
      check("ref_count", n_ref, 32'h6);
      check("mux_ref", n_mux, 32'h6);
    end
    // exact feedback ratio for each modulus
    for (int i = 0; i < 4; i++)
    begin
      sel = 2'(i);
      b = 3 + i;
      a = (i == 3) ? b : $unsigned($random(seed)) % (b + 1);
      n = b * modulus(sel) + a;
      load_word(fn_word(sel, 3'h0, 1'b0, 1'b0, MUX_FB, 1'b0, 1'b1));
      load_word(fb_word(1'b0, b, a));
      load_word(fn_word(sel, 3'h0, 1'b0, 1'b0, MUX_FB, 1'b0, 1'b0));
      run(n * 2 - 1, 1'b0, 1'b1);
      check("fb_short", n_fb, 32'h1);
      check("mux_fb", n_mux, 32'h1);
      run(1, 1'b0, 1'b1);
      check("fb_last", n_fb, 32'h1);
    end
    // lock, lose it on an 80 ns skew, regain it after counter reset
    load_word(ref_word(24));
    load_word(fb_word(1'($random(seed)), 3, 0));
    lock_up();
    check("lock", lock_o, 32'h1);
    check("mux_lock", mux_o, 32'h1);
    run(1, 1'b0, 1'b1);
    run(24 * 2, 1'b1, 1'b1);
    check("unlock", lock_o, 32'h0);
    lock_up();
    check("relock", lock_o, 32'h1);
    // soft power-down, latches still load, then chip enable
    load_word(fn_word(2'h0, 3'h5, 1'b0, 1'b0, MUX_LOCK, 1'b1, 1'b0));
    check("soft_pd", pd_o, 32'h1);
    check("pd_tri", tri_o, 32'h1);
    check("pd_lock", lock_o, 32'h0);
    check("pd_load", cur_o, 32'h5);
    load_word(fn_word(2'h0, 3'h2, 1'b0, 1'b0, MUX_LOCK, 1'b0, 1'b0));
    check("pd_off", pd_o, 32'h0);
    ce = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("ce_pd", pd_o, 32'h1);
    run(30, 1'b1, 1'b1);
    check("ce_quiet", n_ref + n_fb, 32'h0);
    load_word(fn_word(2'h0, 3'h6, 1'b0, 1'b0, MUX_LOCK, 1'b0, 1'b0));
    check("ce_load", cur_o, 32'h6);
    end_of_test();
  end
endmodule : psd_core_tb
